// ---- rtl/cbsc_defs.svh ----
// Constants for the bridge system control and multimedia registers
`ifndef CBSC_DEFS_SVH
`define CBSC_DEFS_SVH

// ==========================================================
// Offsets
`define CBSC_SYSCTL_OFF 8'h80
`define CBSC_MMCTL_OFF 8'h84

// ==========================================================
// System control field positions
`define CBSC_B_BURST_DN 15
`define CBSC_B_BURST_UP 14
`define CBSC_B_ACTIVITY 13
`define CBSC_B_RAIL 12
`define CBSC_B_STREAM 11
`define CBSC_B_UPWAIT 10
`define CBSC_B_DNWAIT 9
`define CBSC_B_INTERROG 8
`define CBSC_B_CLKGATE 6
`define CBSC_B_IDLOCK 5
`define CBSC_B_PARSERR 4
`define CBSC_B_CDMA 3
`define CBSC_B_CLOCK_STOP_INHIBIT 1
`define CBSC_B_WAKEMUX 0

// ==========================================================
// Multimedia field positions and writable mask
`define CBSC_B_VID_OE 7
`define CBSC_B_VID_SEL 6
`define CBSC_MM_WMASK 8'hC3
`define CBSC_MM_RESET 8'h00

// ==========================================================
// Reset values of global controls
`define CBSC_RST_BURST_DN 1'h1
`define CBSC_RST_IDLOCK 1'h1

// ==========================================================
// Timing: period and power switch times
`define CBSC_CLK_PERIOD_NS 10
`define CBSC_STREAM_NS 1000
`define CBSC_PWRUP_NS 2000
`define CBSC_PWRDN_NS 2000
`define CBSC_STREAM_CYC (`CBSC_STREAM_NS / `CBSC_CLK_PERIOD_NS)
`define CBSC_PWRUP_CYC (`CBSC_PWRUP_NS / `CBSC_CLK_PERIOD_NS)
`define CBSC_PWRDN_CYC (`CBSC_PWRDN_NS / `CBSC_CLK_PERIOD_NS)

`endif

// ---- rtl/cbsc_pkg.sv ----
// Types shared by the system control block
package cbsc_pkg;

    typedef enum logic [3:0] {
        CBSC_PS_IDLE = 4'h1,
        CBSC_PS_STREAM = 4'h2,
        CBSC_PS_UPWAIT = 4'h4,
        CBSC_PS_DNWAIT = 4'h8
    } cbsc_pstate_t;

    typedef struct packed {
        cbsc_pstate_t st;
        logic dirUp;
        logic [15:0] cnt;
    } cbsc_seq_state_t;

    typedef struct packed {
        logic burstDn;
        logic burstUp;
        logic [1:0] activity;
        logic clkGate;
        logic idLock;
        logic parSerr;
        logic cdma;
        logic clock_stop_inhibit;
        logic wakeMux;
        logic [7:0] mm;
        logic [31:0] rdData;
        logic rdValid;
        logic [1:0] cbGate;
        logic serr;
        logic irq7;
        logic irq6;
        logic wakePin;
        logic pciStopOk;
        logic cbStopOk;
    } cbsc_state_t;

endpackage : cbsc_pkg

// ---- rtl/cbsc_pwr_if.sv ----
// Power switch request and status between control and sequencer
`timescale 1ns/1ns
`default_nettype none
interface cbsc_pwr_if;
    logic req;
    logic reqUp;
    logic streamBusy;
    logic upWait;
    logic dnWait;
    modport ctl (output req, output reqUp,
                 input streamBusy, input upWait, input dnWait);
    modport seq (input req, input reqUp,
                 output streamBusy, output upWait, output dnWait);
endinterface : cbsc_pwr_if
`default_nettype wire

// ---- rtl/cbsc_pwr_seq.sv ----
// Power switch stream and settle delay sequencer
`timescale 1ns/1ns
`default_nettype none
`include "cbsc_defs.svh"
module cbsc_pwr_seq import cbsc_pkg::*; #(
    parameter int STREAM_CYC = `CBSC_STREAM_CYC,
    parameter int PWRUP_CYC = `CBSC_PWRUP_CYC,
    parameter int PWRDN_CYC = `CBSC_PWRDN_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    cbsc_pwr_if.seq pwr
);
    cbsc_seq_state_t s_reg;
    cbsc_seq_state_t s_next;

    always_comb begin
        s_next = s_reg;
        unique case (s_reg.st)
            CBSC_PS_IDLE: begin
                if (pwr.req) begin
                    s_next.st = CBSC_PS_STREAM;
                    s_next.dirUp = pwr.reqUp;
                    s_next.cnt = 16'(STREAM_CYC - 1);
                end
            end
            CBSC_PS_STREAM: begin
                if (s_reg.cnt != 16'h0000) begin
                    s_next.cnt = s_reg.cnt - 16'h0001;
                end else if (s_reg.dirUp) begin
                    s_next.st = CBSC_PS_UPWAIT;
                    s_next.cnt = 16'(PWRUP_CYC - 1);
                end else begin
                    s_next.st = CBSC_PS_DNWAIT;
                    s_next.cnt = 16'(PWRDN_CYC - 1);
                end
            end
            CBSC_PS_UPWAIT, CBSC_PS_DNWAIT: begin
                if (s_reg.cnt != 16'h0000) begin
                    s_next.cnt = s_reg.cnt - 16'h0001;
                end else begin
                    s_next.st = CBSC_PS_IDLE;
                end
            end
            default: s_next.st = CBSC_PS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            s_reg <= '{st: CBSC_PS_IDLE, dirUp: 1'h0, cnt: 16'h0000};
        end else begin
            s_reg <= s_next;
        end
    end

    // Busy covers stream plus settle time
    assign pwr.streamBusy = (s_reg.st != CBSC_PS_IDLE);
    assign pwr.upWait = (s_reg.st == CBSC_PS_UPWAIT);
    assign pwr.dnWait = (s_reg.st == CBSC_PS_DNWAIT);
endmodule : cbsc_pwr_seq
`default_nettype wire

// ---- rtl/cbsc_sys_ctl.sv ----
// System control low half and multimedia port mapping registers
`timescale 1ns/1ns
`default_nettype none
`include "cbsc_defs.svh"
module cbsc_sys_ctl import cbsc_pkg::*; #(
    parameter int STREAM_CYC = `CBSC_STREAM_CYC,
    parameter int PWRUP_CYC = `CBSC_PWRUP_CYC,
    parameter int PWRDN_CYC = `CBSC_PWRDN_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    // Configuration access
    input wire logic cfgFunc,
    input wire logic [7:0] cfgAddr,
    input wire logic cfgRead,
    input wire logic cfgWrite,
    input wire logic [3:0] cfgByteEn,
    input wire logic [31:0] cfgWrData,
    output logic [31:0] cfgRdData,
    output logic cfgRdValid,
    // Socket side events
    input wire logic [1:0] socketAccess,
    input wire logic [1:0] interrogating,
    input wire logic pwrReq,
    input wire logic pwrReqUp,
    input wire logic [1:0] cardInserted,
    input wire logic [1:0] cardIdle,
    input wire logic [1:0] cbClockRunning,
    input wire logic cardParityErr,
    input wire logic irqMuxIn7,
    input wire logic irqMuxIn6,
    input wire logic ringIndicateReq,
    input wire logic pmeReq,
    // Controls
    output logic read_burst_down_en,
    output logic read_burst_up_en,
    output logic id_regs_write_lock,
    output logic central_dma_en,
    output logic [1:0] cbMachineClkOff,
    output logic serrOut,
    output logic irq_mux_out7,
    output logic irq_mux_out6,
    output logic wakePinOut,
    output logic pciClkStopAllow,
    output logic cbClkStopAllow,
    output logic video_port_out_en,
    output logic video_socket_select
);
    cbsc_state_t s_reg;
    cbsc_state_t s_next;
    cbsc_pwr_if pwr ();

    // ======================================================
    // Power switch sequencer
    assign pwr.req = pwrReq;
    assign pwr.reqUp = pwrReqUp;

    cbsc_pwr_seq #(
        .STREAM_CYC(STREAM_CYC),
        .PWRUP_CYC(PWRUP_CYC),
        .PWRDN_CYC(PWRDN_CYC)
    ) u_seq (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pwr(pwr)
    );

    // ======================================================
    // Decode
    logic hitSys;
    logic hitMm;
    assign hitSys = (cfgAddr == `CBSC_SYSCTL_OFF);
    assign hitMm = (cfgAddr == `CBSC_MMCTL_OFF);

    // ======================================================
    // Next state
    always_comb begin
        logic [15:0] sysVal;
        sysVal = 16'h0000;
        s_next = s_reg;

        // Global bits are shared; both functions see one copy
        sysVal[`CBSC_B_BURST_DN] = s_reg.burstDn;
        sysVal[`CBSC_B_BURST_UP] = s_reg.burstUp;
        sysVal[`CBSC_B_ACTIVITY] = s_reg.activity[cfgFunc];
        sysVal[`CBSC_B_RAIL] = 1'h1;
        sysVal[`CBSC_B_STREAM] = pwr.streamBusy;
        sysVal[`CBSC_B_UPWAIT] = pwr.upWait;
        sysVal[`CBSC_B_DNWAIT] = pwr.dnWait;
        sysVal[`CBSC_B_INTERROG] = interrogating[cfgFunc];
        sysVal[`CBSC_B_CLKGATE] = s_reg.clkGate;
        sysVal[`CBSC_B_IDLOCK] = s_reg.idLock;
        sysVal[`CBSC_B_PARSERR] = s_reg.parSerr;
        sysVal[`CBSC_B_CDMA] = s_reg.cdma;
        sysVal[`CBSC_B_CLOCK_STOP_INHIBIT] = s_reg.clock_stop_inhibit;
        sysVal[`CBSC_B_WAKEMUX] = s_reg.wakeMux;
        // Bits 7 and 2 stay zero from the init above

        s_next.rdValid = cfgRead;
        if (cfgRead) begin
            if (hitSys) begin
                s_next.rdData = {16'h0000, sysVal};
                s_next.activity[cfgFunc] = 1'h0;
            end else if (hitMm) begin
                s_next.rdData = {24'h000000, s_reg.mm};
            end else begin
                s_next.rdData = 32'h00000000;
            end
        end

        // Event in the read cycle survives the clear
        s_next.activity = s_next.activity | socketAccess;

        if (cfgWrite && hitSys) begin
            if (cfgByteEn[1]) begin
                s_next.burstDn = cfgWrData[`CBSC_B_BURST_DN];
                s_next.burstUp = cfgWrData[`CBSC_B_BURST_UP];
            end
            if (cfgByteEn[0]) begin
                s_next.clkGate = cfgWrData[`CBSC_B_CLKGATE];
                s_next.idLock = cfgWrData[`CBSC_B_IDLOCK];
                s_next.parSerr = cfgWrData[`CBSC_B_PARSERR];
                s_next.cdma = cfgWrData[`CBSC_B_CDMA];
                s_next.clock_stop_inhibit = cfgWrData[`CBSC_B_CLOCK_STOP_INHIBIT];
                s_next.wakeMux = cfgWrData[`CBSC_B_WAKEMUX];
            end
        end
        if (cfgWrite && hitMm && cfgByteEn[0]) begin
            s_next.mm = cfgWrData[7:0] & `CBSC_MM_WMASK;
        end

        // Gate only a card that is in, idle and unclocked
        s_next.cbGate = {2{s_next.clkGate}} & cardInserted & cardIdle
            & ~cbClockRunning;
        s_next.serr = s_next.parSerr & cardParityErr;
        s_next.irq7 = irqMuxIn7 & ~s_next.cdma;
        s_next.irq6 = irqMuxIn6 & ~s_next.cdma;
        // Mux set drives PME alone; mux clear ORs ring and PME onto the pin
        s_next.wakePin = s_next.wakeMux ? pmeReq
            : (ringIndicateReq | pmeReq);
        s_next.pciStopOk = ~s_next.clock_stop_inhibit;
        s_next.cbStopOk = ~s_next.clock_stop_inhibit;
    end

    // ======================================================
    // State register
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            s_reg <= '0;
            s_reg.burstDn <= `CBSC_RST_BURST_DN;
            s_reg.idLock <= `CBSC_RST_IDLOCK;
            s_reg.mm <= `CBSC_MM_RESET;
            s_reg.pciStopOk <= 1'h1;
            s_reg.cbStopOk <= 1'h1;
        end else begin
            s_reg <= s_next;
        end
    end

    // ======================================================
    // Outputs
    assign cfgRdData = s_reg.rdData;
    assign cfgRdValid = s_reg.rdValid;
    assign read_burst_down_en = s_reg.burstDn;
    assign read_burst_up_en = s_reg.burstUp;
    assign id_regs_write_lock = s_reg.idLock;
    assign central_dma_en = s_reg.cdma;
    assign cbMachineClkOff = s_reg.cbGate;
    assign serrOut = s_reg.serr;
    assign irq_mux_out7 = s_reg.irq7;
    assign irq_mux_out6 = s_reg.irq6;
    assign wakePinOut = s_reg.wakePin;
    assign pciClkStopAllow = s_reg.pciStopOk;
    assign cbClkStopAllow = s_reg.cbStopOk;
    assign video_port_out_en = s_reg.mm[`CBSC_B_VID_OE];
    assign video_socket_select = s_reg.mm[`CBSC_B_VID_SEL];
endmodule : cbsc_sys_ctl
`default_nettype wire

// ---- verification/cbsc_sys_ctl_sva.sv ----
// Checker for the system control and multimedia register block
`timescale 1ns/1ns
`default_nettype none
module cbsc_sys_ctl_sva (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [7:0] cfgAddr,
    input wire logic cfgRead,
    input wire logic cfgWrite,
    input wire logic [3:0] cfgByteEn,
    input wire logic [31:0] cfgWrData,
    input wire logic [31:0] cfgRdData,
    input wire logic cfgRdValid,
    input wire logic cardParityErr,
    input wire logic ringIndicateReq,
    input wire logic pmeReq,
    input wire logic read_burst_down_en,
    input wire logic read_burst_up_en,
    input wire logic central_dma_en,
    input wire logic serrOut,
    input wire logic irq_mux_out7,
    input wire logic irq_mux_out6,
    input wire logic wakePinOut,
    input wire logic video_port_out_en,
    input wire logic video_socket_select
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // ==========================================================
    // Register access
    a_rd_answer: assert property (
        cfgRead |=> cfgRdValid) else $error("read not answered");
    a_sys_fixed: assert property (
        cfgRdValid && $past(cfgAddr) == 8'h80 |-> cfgRdData[12]
        && !cfgRdData[7] && !cfgRdData[2] && cfgRdData[31:16] == 16'h0)
        else $error("fixed system control bits wrong");
    a_mm_readonly: assert property (
        cfgRdValid && $past(cfgAddr) == 8'h84
        |-> (cfgRdData & ~32'h000000C3) == 32'h0)
        else $error("multimedia reserved bits set");
    a_burst_write: assert property (
        cfgWrite && cfgAddr == 8'h80 && cfgByteEn[1]
        |=> read_burst_down_en == $past(cfgWrData[15])
        && read_burst_up_en == $past(cfgWrData[14]))
        else $error("burst controls not written");
    a_burst_hold: assert property (
        !cfgWrite |=> $stable(read_burst_down_en)
        && $stable(read_burst_up_en)) else $error("burst controls moved");
    a_dma_mutes: assert property (
        central_dma_en |-> !irq_mux_out7 && !irq_mux_out6)
        else $error("interrupt outputs active under DMA");
    a_serr_cause: assert property (
        serrOut |-> $past(cardParityErr)) else $error("SERR without parity");
    a_wake_cause: assert property (
        wakePinOut |-> $past(ringIndicateReq || pmeReq))
        else $error("wake pin without source");
    a_video_write: assert property (
        cfgWrite && cfgAddr == 8'h84 && cfgByteEn[0]
        |=> video_port_out_en == $past(cfgWrData[7])
        && video_socket_select == $past(cfgWrData[6]))
        else $error("video controls not written");
    c_stream_seen: cover property (cfgRdValid && cfgRdData[11]);
    c_dma_on: cover property (central_dma_en);
    c_wake_on: cover property (wakePinOut);
endmodule : cbsc_sys_ctl_sva
`default_nettype wire

// ---- verification/cbsc_host.sv ----
// Configuration host model issuing register accesses
`timescale 1ns/1ns
`default_nettype none
module cbsc_host (
    input wire logic ref_clk,
    output logic cfgFunc,
    output logic [7:0] cfgAddr,
    output logic cfgRead,
    output logic cfgWrite,
    output logic [3:0] cfgByteEn,
    output logic [31:0] cfgWrData
);
    initial {cfgFunc, cfgAddr, cfgRead, cfgWrite, cfgByteEn, cfgWrData} = '0;
    // ==========================================================
    // One access; address, enables and data idle at the inverse, cfgFunc keeps its value
    task automatic acc(input logic w, f, input logic [7:0] a,
                       input logic [3:0] be, input logic [31:0] d);
        @(negedge ref_clk);
        cfgFunc = w ? 1'h0 : f;
        cfgAddr = a;
        cfgByteEn = be;
        cfgWrData = d;
        cfgRead = ~w;
        cfgWrite = w;
        @(negedge ref_clk);
        cfgRead = 1'h0;
        cfgWrite = 1'h0;
        cfgAddr = ~a;
        cfgByteEn = ~be;
        cfgWrData = ~d;
    endtask : acc
endmodule : cbsc_host
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the system control register block
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic ref_clk = 1'h0;
    logic rst_b = 1'h0;
    logic [1:0] socketAccess = '0, interrogating = '0, cardInserted = '0;
    logic [1:0] cardIdle = '0, cbClockRunning = '0, cbMachineClkOff;
    logic pwrReq = 1'h0, pwrReqUp = 1'h0, cardParityErr = 1'h0;
    logic irqMuxIn7 = 1'h0, irqMuxIn6 = 1'h0;
    logic ringIndicateReq = 1'h0, pmeReq = 1'h0;
    logic cfgFunc, cfgRead, cfgWrite, cfgRdValid, serrOut, wakePinOut;
    logic [7:0] cfgAddr, mm;
    logic [3:0] cfgByteEn;
    logic [31:0] cfgWrData, cfgRdData, base, r;
    logic read_burst_down_en, read_burst_up_en, id_regs_write_lock;
    logic central_dma_en, irq_mux_out7, irq_mux_out6, pciClkStopAllow;
    logic cbClkStopAllow, video_port_out_en, video_socket_select;
    logic [15:0] sc;
    logic [31:0] expQ[$];
    int err_total = 0;
    int checks = 0;
    always #5 ref_clk = ~ref_clk;
    cbsc_host u_host (.ref_clk, .cfgFunc, .cfgAddr, .cfgRead, .cfgWrite,
        .cfgByteEn, .cfgWrData);
    cbsc_sys_ctl #(.STREAM_CYC(2), .PWRUP_CYC(3), .PWRDN_CYC(3)) u_dut (
        .ref_clk, .rst_b, .cfgFunc, .cfgAddr, .cfgRead, .cfgWrite,
        .cfgByteEn, .cfgWrData, .cfgRdData, .cfgRdValid, .socketAccess,
        .interrogating, .pwrReq, .pwrReqUp, .cardInserted, .cardIdle,
        .cbClockRunning, .cardParityErr, .irqMuxIn7, .irqMuxIn6,
        .ringIndicateReq, .pmeReq, .read_burst_down_en, .read_burst_up_en,
        .id_regs_write_lock, .central_dma_en, .cbMachineClkOff, .serrOut,
        .irq_mux_out7, .irq_mux_out6, .wakePinOut, .pciClkStopAllow,
        .cbClkStopAllow, .video_port_out_en, .video_socket_select);
    // ==========================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run;
        if (err_total == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic rd(input logic f, input logic [7:0] a, input logic [31:0] e);
        expQ.push_back(e);
        u_host.acc(1'h0, f, a, 4'h0, 32'h0);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.acc(1'h1, 1'h0, a, 4'h3, d);
    endtask : wr
    // Read answers matched oldest first; a stray answer meets X
    // Sampled mid-cycle so the registered answer has settled
    always @(negedge ref_clk) begin
        if (cfgRdValid === 1'h1) begin
            r = expQ.size() > 0 ? expQ.pop_front() : 32'hX;
            check(cfgRdData, r);
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(46604));
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_b = 1'h1;
        rd(1'h0, 8'h80, 32'h00009020);
        rd(1'h1, 8'h84, 32'h0);
        rd(1'h0, 8'h8C, 32'h0);
        for (int i = 0; i < 8; i++) begin
            sc = i == 0 ? 16'hFFFF : 16'($urandom);
            mm = i == 0 ? 8'hFF : 8'($urandom);
            wr(8'h80, {16'hFFFF, sc});
            wr(8'h84, {24'hFFFFFF, mm});
            base = {16'h0, sc & 16'hC07B | 16'h1000};
            rd(1'h0, 8'h80, base);
            rd(1'h0, 8'h84, {24'h0, mm & 8'hC3});
            {cardInserted, cardIdle, cbClockRunning, cardParityErr,
                irqMuxIn7, irqMuxIn6, ringIndicateReq, pmeReq} = 11'($urandom);
            @(negedge ref_clk);
            check(cbMachineClkOff, {2{sc[6]}} & cardInserted
                & cardIdle & ~cbClockRunning);
            check(serrOut, sc[4] & cardParityErr);
            check({irq_mux_out7, irq_mux_out6},
                {irqMuxIn7, irqMuxIn6} & ~{2{sc[3]}});
            check(wakePinOut,
                sc[0] ? pmeReq : ringIndicateReq | pmeReq);
            check({pciClkStopAllow, cbClkStopAllow}, {2{~sc[1]}});
            check({read_burst_down_en, read_burst_up_en},
                sc[15:14]);
            check({id_regs_write_lock, central_dma_en},
                {sc[5], sc[3]});
            check({video_port_out_en, video_socket_select}, mm[7:6]);
        end
        socketAccess = 2'h2;
        @(negedge ref_clk);
        socketAccess = 2'h0;
        interrogating = 2'h1;
        rd(1'h0, 8'h80, base | 32'h0100);
        rd(1'h1, 8'h80, base | 32'h2000);
        rd(1'h1, 8'h80, base);
        interrogating = 2'h0;
        // Reads land on the last cycle of the stream and the middle cycle of the settle delay
        for (int up = 1; up >= 0; up--) begin
            pwrReq = 1'h1;
            pwrReqUp = 1'(up);
            @(negedge ref_clk);
            pwrReq = 1'h0;
            rd(1'h0, 8'h80, base | 32'h0800);
            rd(1'h0, 8'h80, base | (up ? 32'h0C00 : 32'h0A00));
            @(negedge ref_clk);
            rd(1'h0, 8'h80, base);
        end
        for (int i = 0; i < 20 && expQ.size() > 0; i++) @(posedge ref_clk);
        if (expQ.size() > 0) err_total++;
        complete_run();
    end
endmodule : tb
bind cbsc_sys_ctl cbsc_sys_ctl_sva u_sva (.ref_clk, .rst_b, .cfgAddr,
    .cfgRead, .cfgWrite, .cfgByteEn, .cfgWrData, .cfgRdData, .cfgRdValid,
    .cardParityErr, .ringIndicateReq, .pmeReq, .read_burst_down_en,
    .read_burst_up_en, .central_dma_en, .serrOut, .irq_mux_out7,
    .irq_mux_out6, .wakePinOut, .video_port_out_en, .video_socket_select);
`default_nettype wire
